// ---- rfm_defs.svh ----
// Constants of the rail fault monitor: sizes, offsets, fields, timing
`ifndef RFM_DEFS_SVH
`define RFM_DEFS_SVH
`define RFM_NRAIL      10
`define RFM_VW         12
`define RFM_TW         16
`define RFM_AVG        16
`define RFM_AVG_SH     4
`define RFM_CAL_SH     12
`define RFM_OFF_SH     3
`define RFM_CLK_KHZ    10000
`define RFM_SCAN_US    400
`define RFM_TEMP_MS    100
`define RFM_RSTEP_MS   5
`define RFM_RETRY_CONT 4'hf
`define RFM_A_SEL      8'h00
`define RFM_A_UV       8'h04
`define RFM_A_OV       8'h08
`define RFM_A_LVL      8'h0c
`define RFM_A_MODE     8'h10
`define RFM_A_MISC     8'h14
`define RFM_A_CAL      8'h18
`define RFM_A_OT       8'h1c
`define RFM_A_TEMP     8'h20
`define RFM_A_STAT     8'h24
`define RFM_A_SUM      8'h28
`define RFM_S_TON      0
`define RFM_S_UVW      1
`define RFM_S_UVF      2
`define RFM_S_OVW      3
`define RFM_S_OVF      4
`define RFM_S_TOFF     5
`define RFM_S_OTW      6
`define RFM_S_OTF      7
`define RFM_FAULT_MASK 8'h95
`define RFM_WARN_MASK  8'h6a
`endif

// ---- rfm_pkg.sv ----
// Types of the rail fault monitor
`include "rfm_defs.svh"
package rfm_pkg;
   typedef enum logic [1:0] {RESP_CONT, RESP_IMMED, RESP_DELAYED, RESP_RESEQ} rfm_resp_e;
   typedef enum logic [2:0] {ST_OFF, ST_RAMP, ST_ON, ST_WAIT, ST_HALT, ST_RSQ} rfm_st_e;
   typedef struct packed {
      logic [3:0]  rsvHi;
      logic [11:0] hi;
      logic [3:0]  rsvLo;
      logic [11:0] lo;
   } rfm_lim_s;
   typedef struct packed {
      logic [7:0] filtTime;
      logic [7:0] toffMax;
      logic [7:0] tonMax;
      logic [3:0] retries;
      logic       filtEn;
      logic       tempMon;
      rfm_resp_e  resp;
   } rfm_mode_s;
   typedef struct packed {
      logic [15:0] slaves;
      logic [6:0]  rsv;
      logic        warnGpoEn;
      logic [7:0]  restartDly;
   } rfm_misc_s;
   typedef struct packed {
      logic signed [15:0] hi;
      logic signed [15:0] lo;
   } rfm_pair_s;
   typedef struct packed {
      rfm_lim_s  uv;
      rfm_lim_s  ov;
      rfm_lim_s  lvl;
      rfm_mode_s mode;
      rfm_misc_s misc;
      rfm_pair_s cal;
      rfm_pair_s ot;
   } rfm_cfg_s;
   typedef struct packed {
      rfm_st_e                               st;
      logic [7:0]                            tmr;
      logic [7:0]                            glit;
      logic [3:0]                            retry;
      logic [7:0]                            dly;
      logic [7:0]                            status;
      logic                                  toffDone;
      logic                                  hostW;
      logic [`RFM_TW-1:0]                    hostT;
      logic signed [19:0]                    tsum;
      logic [`RFM_AVG-1:0][`RFM_TW-1:0]      ring;
      logic [3:0]                            rptr;
   } rfm_rail_s;
   typedef struct packed {
      rfm_cfg_s  [`RFM_NRAIL-1:0] cfg;
      rfm_rail_s [`RFM_NRAIL-1:0] rt;
      logic [3:0]                 sel;
      logic [11:0]                cnt400;
      logic [23:0]                cntStep;
      logic [23:0]                cntTemp;
      logic [3:0]                 tempIdx;
      logic [31:0]                rdData;
      logic [`RFM_NRAIL-1:0]      en;
      logic [`RFM_NRAIL-1:0]      offReq;
      logic [`RFM_NRAIL-1:0]      onReq;
      logic [`RFM_NRAIL-1:0]      warnGpo;
      logic                       alert;
   } rfm_state_s;
endpackage : rfm_pkg

// ---- rfm_rail_fault_monitor.sv ----
// Rail fault monitor: limit windows, glitch filter, fault responses, temperatures
`timescale 1ns/1ps
`include "rfm_defs.svh"
module rfm_rail_fault_monitor
   import rfm_pkg::*;
#(
   parameter int NRAIL    = `RFM_NRAIL,
   parameter int STEP_CYC = `RFM_RSTEP_MS * `RFM_CLK_KHZ,
   parameter int TEMP_CYC = `RFM_TEMP_MS * `RFM_CLK_KHZ
) (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     reset,
   // Register port
   input  wire logic [7:0]               addr,
   input  wire logic [31:0]              wrData,
   input  wire logic                     wrEn,
   input  wire logic                     rdEn,
   output logic      [31:0]              rdData,
   // Monitor samples and commands from the device core
   input  wire logic [NRAIL-1:0][11:0]   volt,
   input  wire logic [NRAIL-1:0][11:0]   tempVolt,
   input  wire logic [15:0]              dieTemp,
   input  wire logic [NRAIL-1:0]         railCmd,
   // Rail side
   output logic      [NRAIL-1:0]         railEn,
   output logic      [NRAIL-1:0]         seqOffReq,
   output logic      [NRAIL-1:0]         seqOnReq,
   output logic      [NRAIL-1:0]         warnGpo,
   output logic                          alertOut
);
   localparam int T400_CYC = `RFM_SCAN_US * `RFM_CLK_KHZ / 1000;

   rfm_state_s s_r;
   rfm_state_s s_nxt;
   logic       tick400;
   logic       tickStep;
   logic       tickTemp;
   logic signed [`RFM_TW-1:0] tRep [NRAIL];

   // Remote sensor scaling, fixed point with 12 fraction bits
   function automatic logic [15:0] convTemp(input logic signed [15:0] gain,
                                            input logic signed [15:0] offs,
                                            input logic [11:0] v);
      logic signed [29:0] p;
      p = 30'(gain * $signed({1'b0, v}));
      return 16'(offs + 16'(p >>> `RFM_CAL_SH));
   endfunction : convTemp

   function automatic logic [31:0] pack16(input logic [15:0] v);
      return {16'h0000, v};
   endfunction : pack16

   assign tick400  = s_r.cnt400 == 12'(T400_CYC - 1);
   assign tickStep = s_r.cntStep == 24'(STEP_CYC - 1);
   assign tickTemp = s_r.cntTemp == 24'(TEMP_CYC - 1);

   always_comb begin
      for (int r = 0; r < NRAIL; r++) begin
         tRep[r] = s_r.rt[r].hostW ? s_r.rt[r].hostT
                 : 16'(s_r.rt[r].tsum >>> `RFM_AVG_SH);
      end
   end

   always_comb begin
      rfm_cfg_s    c;
      rfm_rail_s   q;
      logic [7:0]  fl;
      logic        fault;
      logic        fire;
      logic        retryOk;
      logic [11:0] v;
      logic [15:0] smp;
      logic [15:0] selfMask;
      logic        selOk;
      c        = '0;
      q        = '0;
      fl       = '0;
      fault    = 1'b0;
      fire     = 1'b0;
      retryOk  = 1'b0;
      v        = '0;
      smp      = '0;
      selfMask = '0;
      s_nxt    = s_r;
      selOk    = s_r.sel < 4'(NRAIL);
      s_nxt.rdData = '0;
      s_nxt.offReq = '0;
      s_nxt.onReq  = '0;
      s_nxt.cnt400  = tick400 ? '0 : s_r.cnt400 + 12'h001;
      s_nxt.cntStep = tickStep ? '0 : s_r.cntStep + 24'h000001;
      s_nxt.cntTemp = tickTemp ? '0 : s_r.cntTemp + 24'h000001;

      // Register writes; status clear comes first so a same-cycle set wins
      if (wrEn) begin
         if (addr == `RFM_A_SEL) begin
            s_nxt.sel = wrData[3:0];
         end else if (selOk) begin
            case (addr)
               `RFM_A_UV:   s_nxt.cfg[s_r.sel].uv   = wrData;
               `RFM_A_OV:   s_nxt.cfg[s_r.sel].ov   = wrData;
               `RFM_A_LVL:  s_nxt.cfg[s_r.sel].lvl  = wrData;
               `RFM_A_MODE: s_nxt.cfg[s_r.sel].mode = wrData;
               `RFM_A_MISC: s_nxt.cfg[s_r.sel].misc = wrData;
               `RFM_A_CAL:  s_nxt.cfg[s_r.sel].cal  = wrData;
               `RFM_A_OT:   s_nxt.cfg[s_r.sel].ot   = wrData;
               `RFM_A_TEMP: begin
                  s_nxt.rt[s_r.sel].hostT = wrData[15:0];
                  s_nxt.rt[s_r.sel].hostW = 1'b1;
               end
               `RFM_A_STAT: s_nxt.rt[s_r.sel].status =
                               s_r.rt[s_r.sel].status & ~wrData[7:0];
               default: ;
            endcase
         end
      end

      // Register reads, data valid in the next cycle only
      if (rdEn) begin
         if (addr == `RFM_A_SEL) begin
            s_nxt.rdData = {28'h0000000, s_r.sel};
         end else if (addr == `RFM_A_SUM) begin
            for (int r = 0; r < NRAIL; r++) begin
               s_nxt.rdData[r] = |s_r.rt[r].status;
            end
         end else if (selOk) begin
            case (addr)
               `RFM_A_UV:   s_nxt.rdData = s_r.cfg[s_r.sel].uv;
               `RFM_A_OV:   s_nxt.rdData = s_r.cfg[s_r.sel].ov;
               `RFM_A_LVL:  s_nxt.rdData = s_r.cfg[s_r.sel].lvl;
               `RFM_A_MODE: s_nxt.rdData = s_r.cfg[s_r.sel].mode;
               `RFM_A_MISC: s_nxt.rdData = s_r.cfg[s_r.sel].misc;
               `RFM_A_CAL:  s_nxt.rdData = s_r.cfg[s_r.sel].cal;
               `RFM_A_OT:   s_nxt.rdData = s_r.cfg[s_r.sel].ot;
               `RFM_A_TEMP: s_nxt.rdData = pack16(tRep[s_r.sel]);
               `RFM_A_STAT: s_nxt.rdData = {21'h000000, s_r.rt[s_r.sel].st,
                                            s_r.rt[s_r.sel].status};
               default:     s_nxt.rdData = '0;
            endcase
         end
      end

      // Temperature sampling, one rail per slot; host value freezes the input
      if (tickTemp) begin
         s_nxt.tempIdx = (s_r.tempIdx == 4'(NRAIL - 1)) ? '0 : s_r.tempIdx + 4'h1;
         for (int r = 0; r < NRAIL; r++) begin
            if (4'(r) == s_r.tempIdx && !s_nxt.rt[r].hostW) begin
               smp = s_r.cfg[r].mode.tempMon
                   ? convTemp(s_r.cfg[r].cal.hi, s_r.cfg[r].cal.lo, tempVolt[r])
                   : dieTemp;
               s_nxt.rt[r].tsum = s_r.rt[r].tsum + 20'($signed(smp))
                                - 20'($signed(s_r.rt[r].ring[s_r.rt[r].rptr]));
               s_nxt.rt[r].ring[s_r.rt[r].rptr] = smp;
               s_nxt.rt[r].rptr = s_r.rt[r].rptr + 4'h1;
            end
         end
      end

      // Per-rail supervision
      for (int r = 0; r < NRAIL; r++) begin
         c        = s_r.cfg[r];
         q        = s_nxt.rt[r];
         v        = volt[r];
         fl       = '0;
         fire     = 1'b0;
         selfMask = '0;
         selfMask[r] = 1'b1;
         retryOk  = (c.mode.retries != 4'h0) &&
                    (c.mode.retries == `RFM_RETRY_CONT || q.retry < c.mode.retries);
         if (tick400) begin
            fl[`RFM_S_OVW] = v > c.ov.lo;
            fl[`RFM_S_OVF] = v > c.ov.hi;
            if (q.st == ST_ON) begin
               fl[`RFM_S_UVW] = v < c.uv.lo;
               fl[`RFM_S_UVF] = v < c.uv.hi;
            end
            fl[`RFM_S_OTW] = $signed(tRep[r]) > c.ot.lo;
            fl[`RFM_S_OTF] = $signed(tRep[r]) > c.ot.hi;
            if (q.st == ST_RAMP) begin
               if (v >= c.lvl.hi) begin
                  q.st = ST_ON;
               end else if (q.tmr >= c.mode.tonMax) begin
                  fl[`RFM_S_TON] = 1'b1;
               end else begin
                  q.tmr = q.tmr + 8'h01;
               end
            end else if (q.st != ST_ON && !q.toffDone &&
                         v > (c.lvl.lo >> `RFM_OFF_SH)) begin
               if (q.tmr >= c.mode.toffMax) begin
                  fl[`RFM_S_TOFF] = 1'b1;
                  q.toffDone = 1'b1;
               end else begin
                  q.tmr = q.tmr + 8'h01;
               end
            end
            fault  = |(fl & `RFM_FAULT_MASK);
            q.glit = !fault ? 8'h00 : (q.glit == 8'hff) ? q.glit : q.glit + 8'h01;
            fire   = fault && (!c.mode.filtEn || q.glit >= c.mode.filtTime)
                     && (q.st == ST_RAMP || q.st == ST_ON);
         end
         // Status logs every excursion at once, filter or not
         q.status = q.status | fl;
         if (fire && c.mode.resp != RESP_CONT) begin
            q.tmr      = '0;
            q.dly      = '0;
            q.toffDone = 1'b0;
            if (retryOk) begin
               q.retry = q.retry + 4'h1;
               q.st    = ST_WAIT;
            end else begin
               case (c.mode.resp)
                  RESP_DELAYED: begin
                     s_nxt.offReq = s_nxt.offReq | NRAIL'(c.misc.slaves | selfMask);
                     q.st = ST_HALT;
                  end
                  RESP_RESEQ: begin
                     s_nxt.offReq = s_nxt.offReq | NRAIL'(c.misc.slaves | selfMask);
                     q.st = ST_RSQ;
                  end
                  default: q.st = ST_HALT;
               endcase
            end
         end else begin
            case (q.st)
               ST_OFF: begin
                  if (railCmd[r]) begin
                     q.st  = ST_RAMP;
                     q.tmr = '0;
                  end
               end
               ST_WAIT: begin
                  if (tickStep) begin
                     if (q.dly >= c.misc.restartDly) begin
                        q.st  = ST_RAMP;
                        q.tmr = '0;
                     end else begin
                        q.dly = q.dly + 8'h01;
                     end
                  end
               end
               ST_RSQ: begin
                  // A stuck rail that hit the turn-off warning still resequences
                  if (tickStep && (v <= (c.lvl.lo >> `RFM_OFF_SH) || q.toffDone)) begin
                     if (q.dly >= c.misc.restartDly) begin
                        s_nxt.onReq = s_nxt.onReq | NRAIL'(c.misc.slaves | selfMask);
                        q.st    = ST_RAMP;
                        q.tmr   = '0;
                        q.retry = '0;
                     end else begin
                        q.dly = q.dly + 8'h01;
                     end
                  end
               end
               default: ;
            endcase
         end
         if (!railCmd[r] && q.st != ST_OFF) begin
            q.tmr      = (q.st == ST_ON || q.st == ST_RAMP) ? 8'h00 : q.tmr;
            q.toffDone = (q.st == ST_ON || q.st == ST_RAMP) ? 1'b0 : q.toffDone;
            q.st       = ST_OFF;
            q.retry    = '0;
         end
         s_nxt.rt[r]      = q;
         s_nxt.en[r]      = q.st == ST_RAMP || q.st == ST_ON;
         s_nxt.warnGpo[r] = c.misc.warnGpoEn && |(q.status & `RFM_WARN_MASK);
      end
      s_nxt.alert = 1'b0;
      for (int r = 0; r < NRAIL; r++) begin
         s_nxt.alert = s_nxt.alert | (|s_nxt.rt[r].status);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdData    = s_r.rdData;
   assign railEn    = s_r.en;
   assign seqOffReq = s_r.offReq;
   assign seqOnReq  = s_r.onReq;
   assign warnGpo   = s_r.warnGpo;
   assign alertOut  = s_r.alert;

   // Checks on rail 0, continue on rail 1, power-good gating on rail 2
   // Each rail carries one bench scenario, so every antecedent is reached
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_scan;
      tick400 |=> !tick400 [*8];
   endproperty
   a_scan: assert property (p_scan) else $error("scan tick too frequent");

   property p_ovAlert;
      tick400 && volt[0] > s_r.cfg[0].ov.lo |=> alertOut && s_r.rt[0].status[`RFM_S_OVW];
   endproperty
   a_ovAlert: assert property (p_ovAlert) else $error("overvoltage not flagged");

   property p_uvGate;
      tick400 && s_r.rt[2].st != ST_ON && !s_r.rt[2].status[`RFM_S_UVW] && !wrEn
         |=> !s_r.rt[2].status[`RFM_S_UVW];
   endproperty
   a_uvGate: assert property (p_uvGate) else $error("undervoltage checked early");

   property p_cont;
      s_r.cfg[1].mode.resp == RESP_CONT && s_r.rt[1].st == ST_ON && railCmd[1]
         |=> s_r.rt[1].st == ST_ON;
   endproperty
   a_cont: assert property (p_cont) else $error("continue changed rail");

   property p_immed;
      tick400 && s_r.cfg[0].mode.resp == RESP_IMMED && s_r.rt[0].st == ST_ON
         && !s_r.cfg[0].mode.filtEn && volt[0] > s_r.cfg[0].ov.hi |=> !railEn[0];
   endproperty
   a_immed: assert property (p_immed) else $error("no immediate shutdown");

   property p_host;
      s_r.rt[0].hostW |-> tRep[0] == s_r.rt[0].hostT ##1 s_r.rt[0].hostW;
   endproperty
   a_host: assert property (p_host) else $error("host temperature not held");

   property p_alertHold;
      alertOut && !wrEn |=> alertOut;
   endproperty
   a_alertHold: assert property (p_alertHold) else $error("alert dropped");

   property p_cmdOff;
      !railCmd[0] |=> !railEn[0] && s_r.rt[0].st == ST_OFF;
   endproperty
   a_cmdOff: assert property (p_cmdOff) else $error("rail on while commanded off");

   property p_ton;
      tick400 && s_r.rt[2].st == ST_RAMP && railCmd[2] && volt[2] < s_r.cfg[2].lvl.hi
         && s_r.rt[2].tmr >= s_r.cfg[2].mode.tonMax |=> s_r.rt[2].status[`RFM_S_TON];
   endproperty
   a_ton: assert property (p_ton) else $error("turn-on timeout missed");

   c_fault: cover property (s_r.rt[0].st == ST_ON ##1 s_r.rt[0].st == ST_WAIT);
   c_reseq: cover property (seqOnReq[0]);
   c_delay: cover property (seqOffReq[0] && s_r.rt[0].st == ST_HALT);
   c_restart: cover property (s_r.rt[7].st == ST_WAIT);
endmodule : rfm_rail_fault_monitor

// ---- rfm_rail_fault_monitor_tb.sv ----
// Self-checking bench of the rail fault monitor
`timescale 1ns/1ps
`include "rfm_defs.svh"
module rfm_rail_fault_monitor_tb;
   logic              clk = 1'b0;
   logic              reset = 1'b1;
   logic [7:0]        addr = 8'h00;
   logic [31:0]       wrData = 32'h0;
   logic              wrEn = 1'b0;
   logic              rdEn = 1'b0;
   logic [31:0]       rdData;
   logic [31:0]       q;
   logic [9:0][11:0]  volt;
   logic [9:0][11:0]  tgt = '0;
   logic [9:0]        railCmd = '0;
   logic [9:0]        railEn;
   logic [9:0]        warnGpo;
   logic [9:0][11:0]  tempVolt = {10{12'h010}};
   logic [9:0]        seqOffReq;
   logic [9:0]        seqOnReq;
   logic [9:0]        offSeen = '0;
   logic [9:0]        onSeen = '0;
   logic              en7Prev = 1'b0;
   int                rise7 = 0;
   logic              alertOut;
   int                err_count = 0;
   int                tests_run = 0;

   always #50 clk = ~clk;

   // Short timers keep the run well inside the cycle budget
   rfm_rail_fault_monitor #(.STEP_CYC(20), .TEMP_CYC(50)) uut (
      .clk(clk), .reset(reset), .addr(addr), .wrData(wrData), .wrEn(wrEn),
      .rdEn(rdEn), .rdData(rdData), .volt(volt), .tempVolt(tempVolt),
      .dieTemp(16'hffe0), .railCmd(railCmd), .railEn(railEn),
      .seqOffReq(seqOffReq), .seqOnReq(seqOnReq), .warnGpo(warnGpo),
      .alertOut(alertOut));

   // Sticky record of sequencer requests and restarts on the rail side
   always @(posedge clk) begin
      if (!reset) begin
         offSeen <= offSeen | seqOffReq;
         onSeen  <= onSeen | seqOnReq;
         en7Prev <= railEn[7];
         if (railEn[7] && !en7Prev) begin
            rise7 <= rise7 + 1;
         end
      end
   end

   rfm_rail_model #(.NRAIL(10)) rails (
      .clk(clk), .reset(reset), .railEn(railEn), .tgt(tgt), .volt(volt));

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr   <= a;
      wrData <= d;
      wrEn   <= 1'b1;
      @(posedge clk);
      wrEn   <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      // Data stand in the cycle after the strobe; taken at its closing edge
      @(posedge clk);
      q = rdData;
   endtask : rd

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic st(input logic [7:0] exp);
      rd(`RFM_A_STAT);
      chk("status", {24'h0, q[7:0]}, {24'h0, exp});
   endtask : st

   // Waits whole check periods; ends on a rising edge
   task automatic ticks(input int n);
      repeat (n * 4000) @(posedge clk);
   endtask : ticks

   task automatic cfg(input logic [3:0] r, input logic [31:0] uv, input logic [31:0] mode);
      wr(`RFM_A_SEL, {28'h0, r});
      wr(`RFM_A_LVL, 32'h0200_0400);
      wr(`RFM_A_OV, 32'h0600_0500);
      wr(`RFM_A_UV, uv);
      wr(`RFM_A_MODE, mode);
   endtask : cfg

   task automatic complete_run();
      $display("Compares %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      // Well above the expected run of about 70000 cycles
      #9_000_000;
      err_count++;
      complete_run();
   end

   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      // Overtemperature limits out of reach, so only chosen rails flag
      for (int i = 0; i < 10; i++) begin
         wr(`RFM_A_SEL, 32'(i));
         wr(`RFM_A_OT, 32'h7fff_7fff);
      end
      rd(8'hfc);
      chk("unmapped", q, 32'h0);
      chk("idle alert", {31'h0, alertOut}, 32'h0);
      // Remote sensor on rail 5: unit gain, offset 4, input 16 reads 20
      wr(`RFM_A_SEL, 32'h5);
      wr(`RFM_A_CAL, 32'h1000_0004);
      wr(`RFM_A_MODE, 32'h4);
      // Rail 4 holds one die sample of -32 here, so its mean reads -2
      repeat (250) @(posedge clk);
      wr(`RFM_A_SEL, 32'h4);
      rd(`RFM_A_TEMP);
      chk("temp mean", q, 32'h0000_fffe);
      // Immediate shutdown on overvoltage, no restart
      cfg(4'h0, 32'h0, 32'h0005_1401);
      rd(`RFM_A_OV);
      chk("ov limits", q, 32'h0600_0500);
      tgt[0] <= 12'h400;
      railCmd[0] <= 1'b1;
      ticks(2);
      st(8'h00);
      @(posedge clk);
      tgt[0] <= 12'h700;
      for (int i = 0; i < 9000 && railEn[0] === 1'b1; i++) @(negedge clk);
      chk("shut rail", {31'h0, railEn[0]}, 32'h0);
      chk("alert", {31'h0, alertOut}, 32'h1);
      ticks(2);
      chk("no restart", {31'h0, railEn[0]}, 32'h0);
      st(8'h18);
      chk("alert held", {31'h0, alertOut}, 32'h1);
      wr(`RFM_A_STAT, 32'hff);
      st(8'h00);
      chk("alert clear", {31'h0, alertOut}, 32'h0);
      // Continue response keeps the rail up
      cfg(4'h1, 32'h0, 32'h0005_1400);
      tgt[1] <= 12'h400;
      railCmd[1] <= 1'b1;
      ticks(2);
      tgt[1] <= 12'h700;
      ticks(2);
      chk("rail kept", {31'h0, railEn[1]}, 32'h1);
      st(8'h18);
      rd(`RFM_A_SUM);
      chk("summary", q, 32'h2);
      @(posedge clk);
      railCmd[1] <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk("cmd off", {31'h0, railEn[1]}, 32'h0);
      wr(`RFM_A_STAT, 32'hff);
      // Rail never reaches power good: timeout, undervoltage ignored
      cfg(4'h2, 32'h0100_0180, 32'h0005_0200);
      railCmd[2] <= 1'b1;
      ticks(4);
      st(8'h01);
      chk("ramp kept", {31'h0, railEn[2]}, 32'h1);
      // Host temperature drives the overtemperature warning
      wr(`RFM_A_SEL, 32'h3);
      wr(`RFM_A_MISC, 32'h100);
      wr(`RFM_A_OT, 32'h7fff_0050);
      wr(`RFM_A_TEMP, 32'h64);
      ticks(1);
      rd(`RFM_A_STAT);
      chk("ot status", {30'h0, q[7:6]}, 32'h1);
      chk("warn output", {31'h0, warnGpo[3]}, 32'h1);
      wr(`RFM_A_SEL, 32'h0);
      wr(`RFM_A_TEMP, 32'h64);
      rd(`RFM_A_TEMP);
      chk("host temp", q, 32'h64);
      wr(`RFM_A_SEL, 32'h4);
      rd(`RFM_A_TEMP);
      chk("die temp", q, 32'h0000_ffe0);
      wr(`RFM_A_SEL, 32'h5);
      rd(`RFM_A_TEMP);
      chk("remote temp", q, 32'h0000_0014);
      // Resequence, one restart, and filtered delayed shutdown with a slave
      cfg(4'h6, 32'h0, 32'h0005_1403);
      cfg(4'h7, 32'h0, 32'h0005_1411);
      wr(`RFM_A_MISC, 32'h2);
      cfg(4'h8, 32'h0, 32'h0205_140a);
      wr(`RFM_A_MISC, 32'h0200_0000);
      tgt[8:6] <= {3{12'h700}};
      railCmd[8:6] <= 3'h7;
      ticks(3);
      chk("off masks", {22'h0, offSeen}, 32'h340);
      chk("on masks", {22'h0, onSeen}, 32'h40);
      chk("restarts", 32'(rise7), 32'h2);
      chk("delayed off", {31'h0, railEn[8]}, 32'h0);
      complete_run();
   end
endmodule : rfm_rail_fault_monitor_tb

// ---- rfm_rail_model.sv ----
// Behavioural model of the monitored rails behind the enable outputs
`timescale 1ns/1ps
module rfm_rail_model #(
   parameter int NRAIL = 10
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Enables and settle targets
   input  wire logic [NRAIL-1:0]       railEn,
   input  wire logic [NRAIL-1:0][11:0] tgt,
   // Sensed rail codes
   output logic      [NRAIL-1:0][11:0] volt
);
   // One code per cycle, so ramp and discharge take real time
   always_ff @(posedge clk) begin
      for (int r = 0; r < NRAIL; r++) begin
         if (reset)
            volt[r] <= 12'h000;
         else if (volt[r] < (railEn[r] ? tgt[r] : 12'h000))
            volt[r] <= volt[r] + 12'h001;
         else if (volt[r] > (railEn[r] ? tgt[r] : 12'h000))
            volt[r] <= volt[r] - 12'h001;
      end
   end
endmodule : rfm_rail_model
